// >>> verilog/gptu_top.sv
// General purpose timer unit with five timers and an APB register port
`timescale 1ns/100ps

// Notes on behaviour
// - Five 16-bit timers in two modules
// - Timers run alone or chained within module
// - Module one: timer, gated or counter
// - Timer mode prescaled; counter mode external events
// - Gated mode counts while gate active
// - One pin each: gate or clock
// - Module one finest period 400 ns
// - Software direction, optional pin override
// - Core and aux b toggle on wrap
// - Latch drives pin and clocks auxiliaries
// - Auxiliary as capture/reload stops counting
// - Capture core value on pin edge
// - Reload core on pin or latch edge
// - Opposite-edge reloads give continuous PWM
// - Module two finest period 200 ns
// - Module two prescaled or external clock
// - Core two latch clocks aux, drives pin
// - Core two wrap clocks CC, reloads
// - Capture aux two on capture pin edge
// - Optionally clear aux two after capture
module gptu_top #(
  parameter int ABW = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ABW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [4:0] timer_gate_clock_pin,
  input wire logic [4:0] timer_direction_pin,
  input wire logic capture_input_pin,
  output logic [2:0] toggle_output_pin,
  output logic [5:0] irq_req,
  output logic cc_clk_pulse
);

  // ==========================================================================
  // Constants
  // ==========================================================================
  localparam int ORD [5] = '{gptu_pkg::IX_CORE1, gptu_pkg::IX_CORE2,
    gptu_pkg::IX_AUXA, gptu_pkg::IX_AUXB, gptu_pkg::IX_AUX2};
  localparam int I_CTRL = gptu_pkg::OFS_CTRL0 / 4;   // Word indices
  localparam int I_CNT = gptu_pkg::OFS_CNT0 / 4;
  localparam int I_MOD2_CAPTURE_RELOAD_REG = gptu_pkg::OFS_MOD2_CAPTURE_RELOAD_REG / 4;
  localparam int I_CAPCTL = gptu_pkg::OFS_CAPCTL / 4;
  localparam int I_STAT = gptu_pkg::OFS_STAT / 4;
  localparam int OTL_SRC [3] = '{gptu_pkg::IX_CORE1, gptu_pkg::IX_AUXB, gptu_pkg::IX_CORE2};

  // Address must reach the last register and the unmapped space above it
  if (ABW < 7 || ABW > 32)
  begin : g_bad_abw
    $error("gptu_top: ABW must be 7 to 32");
  end

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [4:0][15:0] ctrl;     // Control words
    logic [4:0][15:0] cnt;      // Timer counts
    logic [15:0] mod2_capture_reload_reg;        // Capture/reload register
    logic [2:0] capctl;         // Capture control
    logic [7:0] div1;           // Base divider, module one
    logic [7:0] div2;           // Base divider, module two
    logic [7:0] pc1;            // Prescale chain, module one
    logic [7:0] pc2;            // Prescale chain, module two
    logic [10:0] sy1;           // Synchroniser first stage
    logic [10:0] sy2;           // Synchroniser second stage
    logic [10:0] prv;           // Previous level for edges
    logic [2:0] otl;            // Toggle latches
    logic [2:0] tog;            // Toggle pin drive
    logic [5:0] irq;            // Request pulses
    logic cc;                   // Core two wrap pulse
    logic [31:0] prdata;        // Read data
    logic pready;               // Access phase ready
    logic pslverr;              // Unmapped access
  } gptu_state_t;

  gptu_state_t st_r;
  gptu_state_t st_nxt;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // One count step; top bit flags a wrap
  function automatic logic [16:0] gptu_step(input logic [15:0] c, input logic en, input logic dn);
    logic [16:0] r;
    r = {1'b0, c};
    if (en && dn)
    begin
      r = {c == 16'h0000, c - 16'h0001};
    end
    else if (en)
    begin
      r = {c == 16'hffff, c + 16'h0001};
    end
    return r;
  endfunction

  // Word index of an address, or all ones when misaligned
  function automatic int gptu_index(input logic [ABW-1:0] a);
    int r;
    r = (a[1:0] == 2'b00) ? int'(a >> 2) : -1;
    return r;
  endfunction

  // ==========================================================================
  // Next state
  // ==========================================================================
  // All behaviour in one pass; cores before auxiliaries so chain events exist
  always_comb
  begin
    logic b1;
    logic b2;
    logic [10:0] rise;
    logic [10:0] fall;
    logic [4:0] evv;
    logic [4:0] wraps;
    logic [2:0] tev;
    logic [15:0] ctl;
    logic [7:0] msk;
    logic [7:0] pcv;
    logic pre;
    logic chv;
    logic en;
    logic dn;
    logic trg;
    logic cev;
    logic [16:0] sv;
    gptu_pkg::gptu_mode_t mode;
    int i;
    int idx;
    b1 = 1'b0;
    b2 = 1'b0;
    rise = '0;
    fall = '0;
    evv = '0;
    wraps = '0;
    tev = '0;
    ctl = '0;
    msk = '0;
    pcv = '0;
    pre = 1'b0;
    chv = 1'b0;
    en = 1'b0;
    dn = 1'b0;
    trg = 1'b0;
    cev = 1'b0;
    sv = '0;
    mode = gptu_pkg::GPTU_TIMER;
    i = 0;
    idx = 0;
    st_nxt = st_r;

    // Pins pass two flops; edges come from the second stage only
    st_nxt.sy1 = {capture_input_pin, timer_direction_pin, timer_gate_clock_pin};
    st_nxt.sy2 = st_r.sy1;
    st_nxt.prv = st_r.sy2;
    rise = st_r.sy2 & ~st_r.prv;
    fall = ~st_r.sy2 & st_r.prv;

    // Base dividers give the finest count period of each module
    b1 = (st_r.div1 == 8'(gptu_pkg::M1_DIV - 1));
    b2 = (st_r.div2 == 8'(gptu_pkg::M2_DIV - 1));
    st_nxt.div1 = b1 ? 8'h00 : st_r.div1 + 8'h01;
    st_nxt.div2 = b2 ? 8'h00 : st_r.div2 + 8'h01;
    if (b1)
    begin
      st_nxt.pc1 = st_r.pc1 + 8'h01;
    end
    if (b2)
    begin
      st_nxt.pc2 = st_r.pc2 + 8'h01;
    end

    // Pin edge events per timer, filtered by the edge select bits
    for (int j = 0; j < gptu_pkg::NT; j++)
    begin
      evv[j] = (st_r.ctrl[j][gptu_pkg::F_ERISE] & rise[j]) |
               (st_r.ctrl[j][gptu_pkg::F_EFALL] & fall[j]);
    end

    // Count all five timers, cores first
    for (int k = 0; k < gptu_pkg::NT; k++)
    begin
      i = ORD[k];
      ctl = st_r.ctrl[i];
      mode = gptu_pkg::gptu_mode_t'(ctl[gptu_pkg::F_MODE +: 2]);
      pcv = (i < gptu_pkg::IX_AUX2) ? st_r.pc1 : st_r.pc2;
      msk = 8'((9'h001 << ctl[gptu_pkg::F_PS +: 3]) - 9'h001);
      // Prescaled tick: base tick times a power of two
      pre = ((i < gptu_pkg::IX_AUX2) ? b1 : b2) & ((pcv & msk) == msk);
      // Chained clock from the module's core toggle latch
      if (i == gptu_pkg::IX_AUX2)
      begin
        chv = tev[2];
      end
      else if (i == gptu_pkg::IX_CORE1 || i == gptu_pkg::IX_CORE2)
      begin
        chv = 1'b0;
      end
      else
      begin
        chv = tev[0];
      end
      unique case (mode)
        gptu_pkg::GPTU_TIMER:
        begin
          en = pre;
        end
        gptu_pkg::GPTU_GATED:
        begin
          // Gate level compared with the software polarity bit
          en = pre & (st_r.sy2[i] == ctl[gptu_pkg::F_GLVL]);
        end
        gptu_pkg::GPTU_COUNTER:
        begin
          en = ctl[gptu_pkg::F_CHAIN] ? chv : evv[i];
        end
        gptu_pkg::GPTU_AUX:
        begin
          // Auxiliaries hold still as capture/reload; others time normally
          en = (i == gptu_pkg::IX_AUXA || i == gptu_pkg::IX_AUXB) ? 1'b0 : pre;
        end
      endcase
      en = en & ctl[gptu_pkg::F_RUN];
      // Pin high inverts the software direction when enabled
      dn = ctl[gptu_pkg::F_DOWN] ^ (ctl[gptu_pkg::F_EUD] & st_r.sy2[5 + i]);
      sv = gptu_step(st_r.cnt[i], en, dn);
      st_nxt.cnt[i] = sv[15:0];
      wraps[i] = sv[16];
      // Toggle latches flip on each wrap of their timer
      if (i == gptu_pkg::IX_CORE1)
      begin
        tev[0] = sv[16];
      end
      else if (i == gptu_pkg::IX_AUXB)
      begin
        tev[1] = sv[16];
      end
      else if (i == gptu_pkg::IX_CORE2)
      begin
        tev[2] = sv[16];
      end
    end
    st_nxt.otl = st_r.otl ^ tev;

    // Core two reloads from the capture/reload register on wrap
    if (wraps[gptu_pkg::IX_CORE2] && st_r.ctrl[gptu_pkg::IX_CORE2][gptu_pkg::F_T6REL])
    begin
      st_nxt.cnt[gptu_pkg::IX_CORE2] = st_r.mod2_capture_reload_reg;
    end

    // Auxiliaries a and b as capture or reload registers of core one
    for (int j = 0; j < 2; j++)
    begin
      i = 2 * j;
      ctl = st_r.ctrl[i];
      if (ctl[gptu_pkg::F_MODE +: 2] == 2'(gptu_pkg::GPTU_AUX))
      begin
        if (!ctl[gptu_pkg::F_REL])
        begin
          if (evv[i])
          begin
            st_nxt.cnt[i] = st_r.cnt[gptu_pkg::IX_CORE1];
          end
        end
        else
        begin
          // Latch edge: rise select on 0 to 1, fall select on 1 to 0
          trg = ctl[gptu_pkg::F_TRG] ?
                ((ctl[gptu_pkg::F_ERISE] & tev[0] & ~st_r.otl[0]) |
                 (ctl[gptu_pkg::F_EFALL] & tev[0] & st_r.otl[0])) : evv[i];
          // With opposite edges on a and b the core alternates periods
          if (trg)
          begin
            st_nxt.cnt[gptu_pkg::IX_CORE1] = st_r.cnt[i];
          end
        end
      end
    end

    // Capture of auxiliary two on the capture pin
    cev = (st_r.capctl[gptu_pkg::F_CRISE] & rise[gptu_pkg::IX_CAPTURE_INPUT_PIN]) |
          (st_r.capctl[gptu_pkg::F_CFALL] & fall[gptu_pkg::IX_CAPTURE_INPUT_PIN]);
    if (cev)
    begin
      st_nxt.mod2_capture_reload_reg = st_r.cnt[gptu_pkg::IX_AUX2];
      if (st_r.capctl[gptu_pkg::F_CCLR])
      begin
        st_nxt.cnt[gptu_pkg::IX_AUX2] = 16'h0000;
      end
    end

    // Request pulses and the wrap clock for the compare timers
    st_nxt.irq = {cev, wraps};
    st_nxt.cc = wraps[gptu_pkg::IX_CORE2];
    for (int j = 0; j < 3; j++)
    begin
      st_nxt.tog[j] = st_nxt.otl[j] & st_r.ctrl[OTL_SRC[j]][gptu_pkg::F_OE];
    end

    // APB: setup cycle decodes and loads read data; access completes
    st_nxt.pready = 1'b0;
    idx = gptu_index(paddr);
    if (psel && !penable)
    begin
      st_nxt.pready = 1'b1;
      st_nxt.pslverr = (idx < 0) || (idx > I_STAT);
      st_nxt.prdata = 32'h0000_0000;
      if (idx >= I_CTRL && idx < I_CTRL + gptu_pkg::NT)
      begin
        st_nxt.prdata = {16'h0000, st_r.ctrl[idx - I_CTRL]};
      end
      else if (idx >= I_CNT && idx < I_CNT + gptu_pkg::NT)
      begin
        st_nxt.prdata = {16'h0000, st_r.cnt[idx - I_CNT]};
      end
      else if (idx == I_MOD2_CAPTURE_RELOAD_REG)
      begin
        st_nxt.prdata = {16'h0000, st_r.mod2_capture_reload_reg};
      end
      else if (idx == I_CAPCTL)
      begin
        st_nxt.prdata = {29'h0000_0000, st_r.capctl};
      end
      else if (idx == I_STAT)
      begin
        st_nxt.prdata = {29'h0000_0000, st_r.otl};
      end
    end
    // Software writes win over counting, capture and reload
    if (psel && penable && st_r.pready && pwrite)
    begin
      if (idx >= I_CTRL && idx < I_CTRL + gptu_pkg::NT)
      begin
        st_nxt.ctrl[idx - I_CTRL] = pwdata[15:0];
      end
      else if (idx >= I_CNT && idx < I_CNT + gptu_pkg::NT)
      begin
        st_nxt.cnt[idx - I_CNT] = pwdata[15:0];
      end
      else if (idx == I_MOD2_CAPTURE_RELOAD_REG)
      begin
        st_nxt.mod2_capture_reload_reg = pwdata[15:0];
      end
      else if (idx == I_CAPCTL)
      begin
        st_nxt.capctl = pwdata[2:0];
      end
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  // Whole state in one flop bank; constants only under reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_r <= '0;
      st_r.ctrl <= {gptu_pkg::NT{gptu_pkg::RST_CTRL}};
      st_r.cnt <= {gptu_pkg::NT{gptu_pkg::RST_CNT}};
      st_r.capctl <= gptu_pkg::RST_CAPCTL;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Outputs, all straight from flops
  // ==========================================================================
  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign toggle_output_pin = st_r.tog;
  assign irq_req = st_r.irq;
  assign cc_clk_pulse = st_r.cc;

endmodule // gptu_top

// >>> verilog/gptu_pkg.sv
// Package of constants and types for the general purpose timer unit
package gptu_pkg;

  // ==========================================================================
  // Sizes and timer indices
  // ==========================================================================
  localparam int TW = 16;                  // Width of every timer
  localparam int NT = 5;                   // Number of timers
  localparam int IX_AUXA = 0;              // Module one auxiliary timer a
  localparam int IX_CORE1 = 1;             // Module one core timer
  localparam int IX_AUXB = 2;              // Module one auxiliary timer b
  localparam int IX_AUX2 = 3;              // Module two auxiliary timer
  localparam int IX_CORE2 = 4;             // Module two core timer
  localparam int IX_CAPTURE_INPUT_PIN = 10;            // Capture pin within synchronised vector

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 10;       // System clock period
  localparam int M1_RES_NS = 400;          // Finest count period, module one
  localparam int M2_RES_NS = 200;          // Finest count period, module two
  localparam int M1_DIV = (M1_RES_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int M2_DIV = (M2_RES_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // Register byte offsets
  // ==========================================================================
  localparam logic [11:0] OFS_CTRL0 = 12'h000;   // Five control words
  localparam logic [11:0] OFS_CNT0 = 12'h014;    // Five count words
  localparam logic [11:0] OFS_MOD2_CAPTURE_RELOAD_REG = 12'h028;  // Capture/reload register
  localparam logic [11:0] OFS_CAPCTL = 12'h02c;  // Capture control
  localparam logic [11:0] OFS_STAT = 12'h030;    // Toggle latch status

  // ==========================================================================
  // Control word and capture control fields
  // ==========================================================================
  localparam int F_PS = 0;                 // Prescale select, 3 bits
  localparam int F_MODE = 3;               // Mode, 2 bits
  localparam int F_GLVL = 5;               // Active gate level
  localparam int F_RUN = 6;                // Run
  localparam int F_DOWN = 7;               // Count down
  localparam int F_EUD = 8;                // Direction pin enable
  localparam int F_OE = 9;                 // Toggle latch to output pin
  localparam int F_ERISE = 10;             // Act on rising edge
  localparam int F_EFALL = 11;             // Act on falling edge
  localparam int F_REL = 12;               // Auxiliary: reload, else capture
  localparam int F_TRG = 13;               // Reload on toggle latch edge
  localparam int F_CHAIN = 14;             // Count toggle latch transitions
  localparam int F_T6REL = 15;             // Core two reload on wrap
  localparam int F_CRISE = 0;              // Capture on rising edge
  localparam int F_CFALL = 1;              // Capture on falling edge
  localparam int F_CCLR = 2;               // Clear auxiliary after capture

  // ==========================================================================
  // Reset values and modes
  // ==========================================================================
  localparam logic [15:0] RST_CTRL = 16'h0000;
  localparam logic [15:0] RST_CNT = 16'h0000;
  localparam logic [2:0] RST_CAPCTL = 3'h0;

  typedef enum logic [1:0] {
    GPTU_TIMER,
    GPTU_GATED,
    GPTU_COUNTER,
    GPTU_AUX
  } gptu_mode_t;

endpackage

// >>> verif/gptu_chk.sv
// Port checker for the timer unit, bound to its top module
`timescale 1ns/100ps
// ==========
// Checker
// ==========
module gptu_chk #(
  parameter int ABW = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ABW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [4:0] timer_gate_clock_pin,
  input wire logic [4:0] timer_direction_pin,
  input wire logic capture_input_pin,
  input wire logic [2:0] toggle_output_pin,
  input wire logic [5:0] irq_req,
  input wire logic cc_clk_pulse
);
  // One clock domain, so one default for all
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Bus answers in the single access cycle
  chk_ready_setup: assert property (psel && !penable |=> pready) else $error("no pready after setup");
  chk_ready_access: assert property (pready |-> psel && penable) else $error("pready outside access");
  chk_err_unmapped: assert property (psel && !penable && !pwrite && paddr[6:0] == 7'h40
    |=> pslverr && prdata == 32'h0) else $error("unmapped read not refused");
  // Core one wrap and capture requests are single pulses
  chk_irq_pulse: assert property (irq_req[1] |=> !irq_req[1]) else $error("core wrap request too long");
  chk_cap_pulse: assert property (irq_req[5] |=> !irq_req[5]) else $error("capture request too long");
  chk_cc_wrap: assert property (cc_clk_pulse == irq_req[4]) else $error("cc pulse apart from wrap");
  // Latch pin moves only on a wrap or a software write; an enable write shows two edges later
  chk_tog_cause: assert property ($changed(toggle_output_pin[0]) |-> irq_req[1]
    || $past(psel && penable && pwrite, 2)) else $error("toggle pin moved without cause");
  chk_tog2_cause: assert property ($changed(toggle_output_pin[2]) |-> irq_req[4]
    || $past(psel && penable && pwrite, 2)) else $error("core two pin moved without cause");
  chk_wrap_flip: assert property (irq_req[1] |-> toggle_output_pin[0] != $past(toggle_output_pin[0])
    || !(toggle_output_pin[0] || $past(toggle_output_pin[0]))) else $error("wrap kept pin");
  cov_wrap: cover property (irq_req[1]);
  cov_cap: cover property (irq_req[5]);
  cov_cc: cover property (cc_clk_pulse);
endmodule // gptu_chk

bind gptu_top gptu_chk #(.ABW(ABW)) i_gptu_chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer_gate_clock_pin(timer_gate_clock_pin), .timer_direction_pin(timer_direction_pin),
  .capture_input_pin(capture_input_pin), .toggle_output_pin(toggle_output_pin), .irq_req(irq_req),
  .cc_clk_pulse(cc_clk_pulse));

// >>> verif/gptu_pins.sv
// Model of the pins around the timer unit
`timescale 1ns/100ps
// ==========
// Pin model
// ==========
module gptu_pins (
  input wire logic clk,
  input wire logic rst,
  input wire logic [5:0] lvl,
  input wire logic [4:0] dir,
  output logic [4:0] gate_clk,
  output logic [4:0] dir_pin,
  output logic cap_pin
);
  // Pins move just after an edge, like real board logic on the same clock
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      gate_clk <= 5'h0;
      dir_pin <= 5'h0;
      cap_pin <= 1'b0;
    end
    else
    begin
      gate_clk <= lvl[4:0];
      dir_pin <= dir;
      cap_pin <= lvl[5];
    end
  end
endmodule // gptu_pins

// >>> verif/gptu_tb_top.sv
// Self-checking bench for the timer unit
`timescale 1ns/100ps
// ==========
// Bench
// ==========
module gptu_tb_top;
  typedef struct {logic [11:0] a; logic [31:0] wd; logic [31:0] rd; logic re;} gptu_row_t;
  typedef struct {int i; logic [31:0] ctl; logic [31:0] ini; logic [4:0] dir; logic [31:0] ex;} gptu_wrap_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [4:0] gpin;
  logic [4:0] dpin;
  logic cpin;
  logic [2:0] tog;
  logic [5:0] irq;
  logic ccp;
  logic [5:0] lvl = 6'h0; // Pin levels asked of the model
  logic [4:0] dir = 5'h0;
  logic cap_seen = 1'b0; // Sticky, since the capture request is one cycle
  int err_count = 0;
  int compares = 0;
  logic [31:0] r;
  logic e;
  logic hit;
  logic cc;
  // Register cases: write, read back
  gptu_row_t rows[8] = '{'{12'h000, 32'habcd1234, 32'h1234, 1'b0}, '{12'h018, 32'hffff5a5a, 32'h5a5a, 1'b0},
    '{12'h02c, 32'hffffffff, 32'h7, 1'b0}, '{12'h030, 32'h7, 32'h0, 1'b0}, '{12'h028, 32'hbeef, 32'hbeef, 1'b0},
    '{12'h010, 32'h8000, 32'h8000, 1'b0}, '{12'h040, 32'h1, 32'h0, 1'b1}, '{12'h002, 32'h1, 32'h0, 1'b1}};
  // Wrap cases: up with pin out, down, pin reversed, aux b, core two
  gptu_wrap_t wraps[5] = '{'{1, 32'h240, 32'hfffe, 5'h0, 32'h0}, '{1, 32'h0c0, 32'h0, 5'h0, 32'hffff},
    '{1, 32'h1c0, 32'hffff, 5'h02, 32'h0}, '{2, 32'h240, 32'hffff, 5'h0, 32'h0}, '{4, 32'h240, 32'hffff, 5'h0, 32'h0}};

  always #5 clk = ~clk;
  always @(posedge clk) if (irq[5] === 1'b1) cap_seen <= 1'b1;

  gptu_top i_gptu_top (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_gate_clock_pin(gpin),
    .timer_direction_pin(dpin), .capture_input_pin(cpin), .toggle_output_pin(tog), .irq_req(irq),
    .cc_clk_pulse(ccp));
  gptu_pins i_gptu_pins (.clk(clk), .rst(rst), .lvl(lvl), .dir(dir), .gate_clk(gpin), .dir_pin(dpin),
    .cap_pin(cpin));

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 16);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      err_count++;
      report_and_stop();
    end
  endtask

  // Bounded wait for one request bit; also notes the cc pulse
  task automatic wait_irq(int b, int lim);
    hit = 1'b0;
    cc = 1'b0;
    repeat (lim)
    begin
      @(posedge clk);
      if (irq[b] === 1'b1)
      begin
        hit = 1'b1;
        cc = ccp;
        break;
      end
    end
  endtask

  task automatic pulse(int b, int n);
    repeat (n)
    begin
      lvl[b] <= 1'b1;
      repeat (4) @(posedge clk);
      lvl[b] <= 1'b0;
      repeat (4) @(posedge clk);
    end
    repeat (6) @(posedge clk);
  endtask

  initial
  begin
    repeat (100000) @(posedge clk);
    err_count++;
    report_and_stop();
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    check("outputs at reset", {tog, irq, ccp}, 32'h0);
    for (int k = 0; k < 13; k++)
    begin
      apb(1'b0, 12'(4 * k), 32'h0);
      check("reset value", r, 32'h0);
    end
    foreach (rows[k])
    begin
      apb(1'b1, rows[k].a, rows[k].wd);
      apb(1'b0, rows[k].a, 32'h0);
      check("read back", r, rows[k].rd);
      check("slave error", e, rows[k].re);
    end
    foreach (wraps[k])
    begin
      dir <= wraps[k].dir;
      apb(1'b1, 12'(20 + 4 * wraps[k].i), wraps[k].ini);
      apb(1'b1, 12'(4 * wraps[k].i), wraps[k].ctl);
      wait_irq(wraps[k].i, 300);
      check("wrap request", hit, 1'b1);
      if (wraps[k].i == 4) check("cc pulse", cc, 1'b1);
      if (k == 0 || k > 2) check("toggle pin", tog[k == 0 ? 0 : k - 2], 1'b1);
      apb(1'b0, 12'(20 + 4 * wraps[k].i), 32'h0);
      check("count after wrap", r, wraps[k].ex);
      if (k == 2 || k == 4)
      begin
        // Step period: two more steps fit before a third
        repeat (2 * (k == 2 ? gptu_pkg::M1_DIV : gptu_pkg::M2_DIV) + 5) @(posedge clk);
        apb(1'b0, 12'(20 + 4 * wraps[k].i), 32'h0);
        check("step period", r, 32'h2);
      end
      apb(1'b1, 12'(4 * wraps[k].i), 32'h0);
    end
    dir <= 5'h0;
    // Gated: no steps with gate low, steps with gate high
    apb(1'b1, 12'h014, 32'h0);
    apb(1'b1, 12'h000, 32'h68);
    repeat (150) @(posedge clk);
    apb(1'b0, 12'h014, 32'h0);
    check("gate closed", r, 32'h0);
    lvl[0] <= 1'b1;
    repeat (150) @(posedge clk);
    apb(1'b0, 12'h014, 32'h0);
    check("gate open", 32'(r >= 32'h2), 32'h1);
    lvl[0] <= 1'b0;
    // Counter: rising edges only, then both edges
    for (int k = 0; k < 2; k++)
    begin
      apb(1'b1, 12'h014, 32'h0);
      apb(1'b1, 12'h000, k ? 32'hc50 : 32'h450);
      pulse(0, 5);
      apb(1'b0, 12'h014, 32'h0);
      check("event count", r, k ? 32'ha : 32'h5);
    end
    apb(1'b1, 12'h000, 32'h0);
    // Aux b captures the stopped core value
    apb(1'b1, 12'h018, 32'h0777);
    apb(1'b1, 12'h01c, 32'h0);
    apb(1'b1, 12'h008, 32'h418);
    pulse(2, 1);
    apb(1'b0, 12'h01c, 32'h0);
    check("aux capture", r, 32'h0777);
    // Capture register takes aux two, then aux two clears
    apb(1'b1, 12'h020, 32'h1234);
    apb(1'b1, 12'h02c, 32'h5);
    pulse(5, 1);
    check("capture request", cap_seen, 1'b1);
    apb(1'b0, 12'h028, 32'h0);
    check("capture value", r, 32'h1234);
    apb(1'b0, 12'h020, 32'h0);
    check("clear after capture", r, 32'h0);
    // Core one reloads from aux a on either latch edge; aux b counts latch edges
    apb(1'b1, 12'h014, 32'hfffe);
    apb(1'b1, 12'h000, 32'h3c18);
    apb(1'b1, 12'h01c, 32'h0);
    apb(1'b1, 12'h008, 32'h4050);
    apb(1'b1, 12'h018, 32'hffff);
    apb(1'b1, 12'h004, 32'h040);
    wait_irq(1, 300);
    check("reload wrap", hit, 1'b1);
    apb(1'b0, 12'h018, 32'h0);
    check("latch reload", r, 32'hfffe);
    apb(1'b0, 12'h01c, 32'h0);
    check("chained count", r, 32'h1);
    apb(1'b1, 12'h004, 32'h0);
    // Core two reloads from the capture register; its latch clocks aux two
    apb(1'b1, 12'h028, 32'hfffe);
    apb(1'b1, 12'h020, 32'hffff);
    apb(1'b1, 12'h00c, 32'h4050);
    apb(1'b1, 12'h024, 32'hffff);
    apb(1'b1, 12'h010, 32'h8040);
    wait_irq(3, 300);
    check("aux two chained wrap", hit, 1'b1);
    apb(1'b0, 12'h024, 32'h0);
    check("core two reload", r, 32'hfffe);
    apb(1'b1, 12'h010, 32'h0);
    report_and_stop();
  end
endmodule // gptu_tb_top
